/* File: verilog/vfes_video_front_end_sampler.sv */
// Video front end: qualified sampling, field identity, cropping, AXI4-Lite registers.
`timescale 1ns/1ps
`include "vfes_cfg.svh"

module vfes_video_front_end_sampler (
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               doubleRateVideoClock,
    input  wire logic               pixelRateQualifier,
    input  wire logic [7:0]         lumaIn,
    input  wire logic [7:0]         chromaIn,
    input  wire logic               hsyncIn,
    input  wire logic               vsyncIn,
    input  wire logic               fieldIndicatorIn,
    input  wire logic [23:0]        pixBusIn,
    output logic [23:0]             pixBusOut,
    output logic                    pixBusOe,
    output logic                    hsyncOut,
    output logic                    vsyncOut,
    output logic                    syncOe,
    output logic                    pixValid,
    output logic [7:0]              lumaOut,
    output logic [7:0]              chromaOut,
    output logic                    fieldTop,
    output vfes_pkg::vfes_mode_t    activeMode,
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    import vfes_pkg::*;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic activeEdge(input logic prev, input logic cur, input logic negSel);
        return negSel ? (prev & ~cur) : (~prev & cur);
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int SW = 45;
    logic [SW-1:0] syncA_q;
    logic [SW-1:0] syncB_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {pixBusIn, fieldIndicatorIn, vsyncIn, hsyncIn, pixelRateQualifier,
                        doubleRateVideoClock, chromaIn, lumaIn};
            syncB_q <= syncA_q;
        end
    end
    logic [7:0]  lumaS;
    logic [7:0]  chromaS;
    logic        v2S;
    logic        qualS;
    logic        hsS;
    logic        vsS;
    logic        fiS;
    logic [23:0] busS;
    assign {busS, fiS, vsS, hsS, qualS, v2S, chromaS, lumaS} = syncB_q;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic [31:0] vwin_q;
    logic [31:0] hwin_q;
    logic [23:0] stillOut_q;
    logic [23:0] stillIn_q;
    logic [9:0]  lineCnt_q;
    logic [9:0]  pixCnt_q;
    logic        field_q;
    vfes_mode_t  mode;
    logic        motionMode;
    assign mode = vfes_mode_t'(ctrl_q[`VFES_CTRL_MODE_HI:`VFES_CTRL_MODE_LO]);
    assign motionMode = (mode == VFES_MCOMP) || (mode == VFES_MDECOMP) || (mode == VFES_STREAM);

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic        awHeld_q;
    logic        wHeld_q;
    logic [11:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        doWrite;
    logic        wrHit;
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wrHit = (awAddr_q == `VFES_OFF_CTRL) || (awAddr_q == `VFES_OFF_VWIN) ||
                   (awAddr_q == `VFES_OFF_HWIN) || (awAddr_q == `VFES_OFF_STILLOUT);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= '0;
            wStrb_q       <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `VFES_RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && !awHeld_q && !s_axi_awready;
            s_axi_wready  <= s_axi_wvalid && !wHeld_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? `VFES_RESP_OKAY : `VFES_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q     <= `VFES_RST_CTRL;
            vwin_q     <= `VFES_RST_WIN;
            hwin_q     <= `VFES_RST_WIN;
            stillOut_q <= '0;
        end else if (doWrite) begin
            if (awAddr_q == `VFES_OFF_CTRL) begin
                ctrl_q <= mergeBytes(ctrl_q, wData_q, wStrb_q) & 32'h0000_373F;
            end else if (awAddr_q == `VFES_OFF_VWIN) begin
                vwin_q <= mergeBytes(vwin_q, wData_q, wStrb_q) & 32'h03FF_03FF;
            end else if (awAddr_q == `VFES_OFF_HWIN) begin
                hwin_q <= mergeBytes(hwin_q, wData_q, wStrb_q) & 32'h03FF_03FF;
            end else if (awAddr_q == `VFES_OFF_STILLOUT) begin
                stillOut_q <= 24'(mergeBytes({8'h00, stillOut_q}, wData_q, wStrb_q));
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `VFES_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `VFES_RESP_OKAY;
                if (s_axi_araddr[11:2] == 10'(`VFES_OFF_CTRL >> 2)) begin
                    s_axi_rdata <= ctrl_q;
                end else if (s_axi_araddr[11:2] == 10'(`VFES_OFF_VWIN >> 2)) begin
                    s_axi_rdata <= vwin_q;
                end else if (s_axi_araddr[11:2] == 10'(`VFES_OFF_HWIN >> 2)) begin
                    s_axi_rdata <= hwin_q;
                end else if (s_axi_araddr[11:2] == 10'(`VFES_OFF_STILLOUT >> 2)) begin
                    s_axi_rdata <= {8'h00, stillOut_q};
                end else if (s_axi_araddr[11:2] == 10'(`VFES_OFF_STATUS >> 2)) begin
                    s_axi_rdata <= {6'h00, lineCnt_q, 2'h0, pixCnt_q, 3'h0, field_q};
                end else if (s_axi_araddr[11:2] == 10'(`VFES_OFF_STILLIN >> 2)) begin
                    s_axi_rdata <= {8'h00, stillIn_q};
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= `VFES_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Qualified sampling and counting
    // ****************************************************************
    logic v2Prev_q;
    logic hsPrev_q;
    logic vsPrev_q;
    logic smpEv;
    logic hsEdge;
    logic vsEdge;
    logic [9:0] pixNext;
    logic [9:0] lineNext;
    logic inWindow;
    // Only one of each pair of double-rate rising edges carries data: the qualifier phase picks it.
    assign smpEv = v2S && !v2Prev_q && (qualS == ctrl_q[`VFES_CTRL_QPOL]);
    assign hsEdge = activeEdge(hsPrev_q, hsS, ctrl_q[`VFES_CTRL_HPOL]);
    assign vsEdge = activeEdge(vsPrev_q, vsS, ctrl_q[`VFES_CTRL_VPOL]);

    always_comb begin
        pixNext = hsEdge ? 10'h000 : ((pixCnt_q == `VFES_CNT_MAX) ? pixCnt_q : pixCnt_q + 10'h001);
        if (vsEdge) begin
            lineNext = 10'h000;
        end else if (hsEdge && lineCnt_q != `VFES_CNT_MAX) begin
            lineNext = lineCnt_q + 10'h001;
        end else begin
            lineNext = lineCnt_q;
        end
        inWindow = (lineNext >= vwin_q[9:0]) && (lineNext <= vwin_q[25:16]) &&
                   (pixNext >= hwin_q[9:0]) && (pixNext <= hwin_q[25:16]);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            v2Prev_q <= 1'b0;
        end else begin
            v2Prev_q <= v2S;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hsPrev_q  <= 1'b0;
            vsPrev_q  <= 1'b0;
            pixCnt_q  <= '0;
            lineCnt_q <= '0;
            field_q   <= 1'b1;
        end else if (smpEv) begin
            hsPrev_q  <= hsS;
            vsPrev_q  <= vsS;
            pixCnt_q  <= pixNext;
            lineCnt_q <= lineNext;
            if (ctrl_q[`VFES_CTRL_USE_EXTERNAL_FIELD_FLAG]) begin
                field_q <= (fiS == ctrl_q[`VFES_CTRL_TOP]);
            end else if (vsEdge) begin
                field_q <= (hsS == ctrl_q[`VFES_CTRL_TOP]);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pixValid  <= 1'b0;
            lumaOut   <= '0;
            chromaOut <= '0;
            fieldTop  <= 1'b1;
            stillIn_q <= '0;
        end else begin
            pixValid <= smpEv && inWindow && motionMode;
            fieldTop <= field_q;
            if (smpEv) begin
                lumaOut   <= lumaS;
                chromaOut <= chromaS;
                if (mode == VFES_SDECOMP) begin
                    stillIn_q <= busS;
                end
            end
        end
    end

    // ****************************************************************
    // Pin drive for sync and still pixel bus
    // ****************************************************************
    // Motion compression and stream modes always take external sync, whatever the sync bit says.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncOe     <= 1'b0;
            hsyncOut   <= 1'b0;
            vsyncOut   <= 1'b0;
            pixBusOe   <= 1'b0;
            pixBusOut  <= '0;
            activeMode <= VFES_MCOMP;
        end else begin
            syncOe <= (ctrl_q[`VFES_CTRL_INTSYNC] && mode == VFES_MDECOMP) || !motionMode;
            hsyncOut   <= ctrl_q[`VFES_CTRL_HSLVL];
            vsyncOut   <= ctrl_q[`VFES_CTRL_VSLVL];
            pixBusOe   <= (mode == VFES_SCOMP);
            pixBusOut  <= stillOut_q;
            activeMode <= mode;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_sample_qualified: assert property (pixValid |-> $past(smpEv))
        else $error("valid pixel without a qualified edge");
    chk_motion_only: assert property (pixValid |-> $past(motionMode))
        else $error("valid pixel outside motion modes");
    // A window write landing with the sample judges that sample by the old window.
    chk_line_range: assert property (pixValid && !$past(doWrite) |->
        lineCnt_q >= vwin_q[9:0] && lineCnt_q <= vwin_q[25:16])
        else $error("valid pixel outside line window");
    chk_pixel_range: assert property (pixValid && !$past(doWrite) |->
        pixCnt_q >= hwin_q[9:0] && pixCnt_q <= hwin_q[25:16])
        else $error("valid pixel outside pixel window");
    chk_pix_restart: assert property (smpEv && hsEdge |=> pixCnt_q == 10'h000)
        else $error("pixel count not restarted at hsync edge");
    chk_line_restart: assert property (smpEv && vsEdge |=> lineCnt_q == 10'h000)
        else $error("line count not restarted at vsync edge");
    chk_ext_field: assert property (smpEv && ctrl_q[1] |=> field_q == ($past(fiS) == $past(ctrl_q[2])))
        else $error("external field sense wrong");
    chk_int_field: assert property (smpEv && !ctrl_q[1] && vsEdge |=> ##1 fieldTop == ($past(hsS, 2) == $past(ctrl_q[2], 2)))
        else $error("internal field sense wrong");
    chk_still_bus: assert property (mode == VFES_SCOMP |=> pixBusOe && syncOe)
        else $error("still bus not driven");
    chk_sync_ext: assert property (mode == VFES_MCOMP || mode == VFES_STREAM |=> !syncOe)
        else $error("sync driven in external sync mode");
    chk_count_sat: assert property (pixCnt_q == `VFES_CNT_MAX && smpEv && !hsEdge |=> pixCnt_q == `VFES_CNT_MAX)
        else $error("pixel count wrapped");

    cov_valid_pixel: cover property (pixValid ##1 !pixValid);
    cov_new_frame: cover property (smpEv && vsEdge);
    cov_still_in: cover property (mode == VFES_SDECOMP && smpEv);
endmodule // vfes_video_front_end_sampler

/* File: verilog/vfes_cfg.svh */
// Offsets, field positions and reset values of the video front end sampler.
`ifndef VFES_CFG_SVH
`define VFES_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VFES_OFF_CTRL     12'h000
`define VFES_OFF_VWIN     12'h004
`define VFES_OFF_HWIN     12'h008
`define VFES_OFF_STILLOUT 12'h00C
`define VFES_OFF_STATUS   12'h010
`define VFES_OFF_STILLIN  12'h014

// ****************************************************************
// Control fields
// ****************************************************************
`define VFES_CTRL_QPOL    0
`define VFES_CTRL_USE_EXTERNAL_FIELD_FLAG   1
`define VFES_CTRL_TOP     2
`define VFES_CTRL_HPOL    3
`define VFES_CTRL_VPOL    4
`define VFES_CTRL_INTSYNC 5
`define VFES_CTRL_MODE_LO 8
`define VFES_CTRL_MODE_HI 10
`define VFES_CTRL_HSLVL   12
`define VFES_CTRL_VSLVL   13

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define VFES_RST_CTRL     32'h0000_0004
`define VFES_RST_WIN      32'h03FF_0000
`define VFES_CNT_MAX      10'h3FF
`define VFES_RESP_OKAY    2'h0
`define VFES_RESP_SLVERR  2'h2

`endif

/* File: verilog/vfes_pkg.sv */
// Types shared by the video front end sampler.
package vfes_pkg;
    typedef enum logic [2:0] {
        VFES_MCOMP   = 3'h0,
        VFES_MDECOMP = 3'h1,
        VFES_STREAM  = 3'h3,
        VFES_SCOMP   = 3'h2,
        VFES_SDECOMP = 3'h6
    } vfes_mode_t;
endpackage

/* File: testbench/vfes_video_source.sv */
// Behavioural video source feeding the sampler's luma, chroma, field and sync pins.
`timescale 1ns/1ps
module vfes_video_source #(
    parameter int PIX = 20,
    parameter int LIN = 8
) (
    output logic       dclk,
    output logic       qual,
    output logic [7:0] luma,
    output logic [7:0] chroma,
    output logic       hsync,
    output logic       vsync,
    output logic       field,
    output int         frameCount
);
    int pix = 0;
    int line = 0;
    int vp;
    initial begin
        dclk = 1'b0;
        qual = 1'b0;
        {luma, chroma, hsync, vsync, field} = 19'h00000;
        frameCount = 0;
    end
    always #62.5 dclk = ~dclk;
    // ****************************************************************
    // Pixel stream
    // ****************************************************************
    // Data is valid only at the edge marked by the qualifier high; the other edge sees inverted bits.
    // The vsync edge falls in the active hsync part before even frames and outside it before odd ones.
    always @(negedge dclk) begin
        qual <= ~qual;
        if (!qual) begin
            pix = pix + 1;
            if (pix == PIX) begin
                pix = 0;
                line = line + 1;
            end
            if (line == LIN) begin
                line = 0;
                frameCount = frameCount + 1;
            end
            vp = (((line == LIN - 1) ? frameCount + 1 : frameCount) % 2 == 0) ? 2 : 12;
            luma <= 8'(pix);
            chroma <= 8'(line);
            hsync <= (pix < 4);
            vsync <= (line == LIN - 1 && pix >= vp) || (line == 0 && pix < vp);
            field <= frameCount[0];
        end else begin
            luma <= ~luma;
            chroma <= ~chroma;
        end
    end
endmodule // vfes_video_source

/* File: testbench/vfes_video_front_end_sampler_bench.sv */
// Self-checking bench: AXI4-Lite register access, cropping, field identity and modes.
`timescale 1ns/1ps
`include "vfes_cfg.svh"
module vfes_video_front_end_sampler_bench;
    import vfes_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic dclk, qual, hsync, vsync, field, pixBusOe, hsyncOut, vsyncOut, syncOe, pixValid, fieldTop;
    logic [7:0] luma, chroma, lumaOut, chromaOut;
    logic [23:0] pixBusOut;
    vfes_mode_t activeMode;
    int frameCount;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int n_mismatch = 0;
    int checked = 0;
    int nValid = 0;
    logic [15:0] firstPix, lastPix;

    always #5 clk = ~clk;

    vfes_video_source src_u (.dclk(dclk), .qual(qual), .luma(luma), .chroma(chroma), .hsync(hsync),
        .vsync(vsync), .field(field), .frameCount(frameCount));

    vfes_video_front_end_sampler dut_u (.clk(clk), .arst_n(arst_n), .doubleRateVideoClock(dclk),
        .pixelRateQualifier(qual), .lumaIn(luma), .chromaIn(chroma), .hsyncIn(hsync), .vsyncIn(vsync),
        .fieldIndicatorIn(field), .pixBusIn(24'h5A5A5A), .pixBusOut(pixBusOut), .pixBusOe(pixBusOe),
        .hsyncOut(hsyncOut), .vsyncOut(vsyncOut), .syncOe(syncOe), .pixValid(pixValid), .lumaOut(lumaOut),
        .chromaOut(chromaOut), .fieldTop(fieldTop), .activeMode(activeMode), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // Outputs are registered, so the falling edge sees each one-cycle pulse exactly once.
    always @(negedge clk) if (pixValid === 1'b1) begin
        if (nValid == 0) firstPix = {lumaOut, chromaOut};
        lastPix = {lumaOut, chromaOut};
        nValid = nValid + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic axiWr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw, w, bv, done;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(negedge clk);
            {aw, w, bv, resp} = {awready & awvalid, wready & wvalid, bvalid, bresp};
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (bv) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar, done;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(negedge clk);
            {ar, done, d, resp} = {arready & arvalid, rvalid, rdata, rresp};
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
    endtask

    task automatic nextFrame();
        int f = frameCount;
        while (frameCount == f) @(posedge clk);
    endtask

    // Collects one even frame, whose vsync edge sits inside the active hsync part.
    task automatic winTest(input logic [31:0] ctrl, input int expN, input logic [15:0] expFirst,
                           input logic [15:0] expLast, input string name);
        axiWr(`VFES_OFF_CTRL, ctrl, rs);
        axiWr(`VFES_OFF_VWIN, 32'h0005_0003, rs);
        axiWr(`VFES_OFF_HWIN, 32'h0009_0005, rs);
        nextFrame();
        while (frameCount % 2 != 0) nextFrame();
        nValid = 0;
        nextFrame();
        chk(32'(nValid), 32'(expN), "valid count");
        chk({16'h0000, firstPix}, {16'h0000, expFirst}, "first sample");
        chk({16'h0000, lastPix}, {16'h0000, expLast}, "last sample");
        $display("test %s done", name);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        n_mismatch++;
        tally_and_finish();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        logic ext, top, still, expTop, intSync;
        vfes_mode_t modes [5] = '{VFES_MCOMP, VFES_MDECOMP, VFES_STREAM, VFES_SCOMP, VFES_SDECOMP};
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        axiRd(`VFES_OFF_CTRL, rd, rs);
        chk(rd, `VFES_RST_CTRL, "control reset");
        axiRd(`VFES_OFF_HWIN, rd, rs);
        chk(rd, `VFES_RST_WIN, "window reset");
        axiRd(12'h020, rd, rs);
        chk({30'h0, rs}, {30'h0, `VFES_RESP_SLVERR}, "unmapped read");
        axiWr(12'h020, 32'hFFFF_FFFF, rs);
        chk({30'h0, rs}, {30'h0, `VFES_RESP_SLVERR}, "unmapped write");
        axiWr(`VFES_OFF_VWIN, 32'h0123_0045, rs);
        axiRd(`VFES_OFF_VWIN, rd, rs);
        chk(rd, 32'h0123_0045, "window readback");
        $display("test registers done");
        // Line count is line index plus one; pixel count equals pixel index, or pixel index minus four on falling edges.
        winTest(32'h0000_0005, 15, 16'h0502, 16'h0904, "window");
        winTest(32'h0000_0004, 15, 16'hFAFD, 16'hF6FB, "qualifier low");
        winTest(32'h0000_001D, 15, 16'h0902, 16'h0D04, "falling edges");
        for (int k = 0; k < 4; k++) begin
            {top, ext} = 2'(k);
            axiWr(`VFES_OFF_CTRL, {29'h0, top, ext, 1'b1}, rs);
            nextFrame();
            repeat (2000) @(posedge clk);
            expTop = (ext ? frameCount[0] : ~frameCount[0]) ~^ top;
            chk({31'h0, fieldTop}, {31'h0, expTop}, "field identity");
        end
        $display("test field done");
        axiWr(`VFES_OFF_HWIN, `VFES_RST_WIN, rs);
        axiWr(`VFES_OFF_VWIN, `VFES_RST_WIN, rs);
        axiWr(`VFES_OFF_STILLOUT, 32'h00AB_CDEF, rs);
        // Internal sync is requested only in motion decompression, the one motion mode allowed to use it.
        foreach (modes[i]) begin
            still = (modes[i] == VFES_SCOMP) || (modes[i] == VFES_SDECOMP);
            intSync = (modes[i] == VFES_MDECOMP);
            axiWr(`VFES_OFF_CTRL, {18'h0, 2'(i), 1'b0, modes[i], 2'b00, intSync, 5'h01}, rs);
            repeat (4) @(posedge clk);
            nValid = 0;
            repeat (1500) @(posedge clk);
            chk({31'h0, nValid > 0}, {31'h0, ~still}, "motion sampling");
            chk({29'h0, activeMode}, {29'h0, modes[i]}, "mode");
            chk({31'h0, pixBusOe}, {31'h0, modes[i] == VFES_SCOMP}, "bus enable");
            chk({8'h0, pixBusOe ? pixBusOut : 24'hABCDEF}, 32'h00AB_CDEF, "still pixel");
            chk({31'h0, syncOe}, {31'h0, still || modes[i] == VFES_MDECOMP}, "sync source");
            chk({30'h0, vsyncOut, hsyncOut}, {30'h0, 2'(i)}, "sync levels");
            if (modes[i] == VFES_SDECOMP) begin
                axiRd(`VFES_OFF_STILLIN, rd, rs);
                chk(rd, 32'h005A_5A5A, "still input");
            end
        end
        $display("test modes done");
        tally_and_finish();
    end
endmodule // vfes_video_front_end_sampler_bench
